// ---- hw/lp_ctrl.sv ----
// Core low-power state control and block clock gating.
// Assumes cores and blocks share CLK; all inputs are same-domain logic.
`timescale 1ns/1ns
`default_nettype none
module lp_ctrl (
   input  wire logic                             CLK,
   input  wire logic                             RESET,
   input  wire lp_pkg::pm_wr_t                   PM_WR,
   input  wire logic [lp_pkg::NCORES-1:0]        PM_WR_ALLOWED,
   input  wire logic [lp_pkg::NCORES-1:0]        INSN_HALT,
   input  wire logic [lp_pkg::NCORES-1:0]        INSN_NAP,
   input  wire logic [lp_pkg::NCORES-1:0]        CORE_WAKE,
   input  wire logic [lp_pkg::NCORES-1:0]        CORE_DISABLE,
   input  wire logic [lp_pkg::NBLOCKS-1:0]       BLK_WORK,
   input  wire logic [lp_pkg::NBLOCKS-1:0]       BLK_DISABLE,
   output lp_pkg::core_ctl_t [lp_pkg::NCORES-1:0] CORE_CTL,
   output logic [lp_pkg::NCORES-1:0]             CORE_BUSY,
   output logic [lp_pkg::NBLOCKS-1:0]            BLK_CLK_EN
);

   typedef enum logic [3:0] {
      S_RUN  = 4'h1,
      S_HALT = 4'h2,
      S_NAP  = 4'h4,
      S_WAKE = 4'h8
   } cst_t;

   cst_t                         st_q   [lp_pkg::NCORES];
   cst_t                         st_d   [lp_pkg::NCORES];
   logic [7:0]                   cnt_q  [lp_pkg::NCORES];
   logic [7:0]                   cnt_d  [lp_pkg::NCORES];
   logic [lp_pkg::NCORES-1:0]    byreg_q, byreg_d;
   logic [lp_pkg::NCORES-1:0]    cdis_q,  cdis_d;
   logic [lp_pkg::NBLOCKS-1:0]   bdis_q,  bdis_d;

   ////////////////////////////////////////////////////////////////////////
   // Per-core next state
   always_comb begin
      logic reg_hit;
      logic reg_clr;
      logic wake;
      reg_hit = 1'b0;
      reg_clr = 1'b0;
      wake    = 1'b0;
      for (int i = 0; i < lp_pkg::NCORES; i++) begin
         st_d[i]    = st_q[i];
         cnt_d[i]   = cnt_q[i];
         byreg_d[i] = byreg_q[i];
         reg_hit = PM_WR.valid && PM_WR_ALLOWED[PM_WR.src]
                   && (PM_WR.target == 2'(i));
         // only another core clears a register sleep
         reg_clr = reg_hit && (PM_WR.mode == lp_pkg::MODE_RUN)
                   && (PM_WR.src != 2'(i));
         // own wake ignored after register entry
         wake = reg_clr || (CORE_WAKE[i] && !byreg_q[i]);
         case (st_q[i])
            S_RUN: begin
               if (reg_hit && PM_WR.mode == lp_pkg::MODE_NAP) begin
                  st_d[i]    = S_NAP;
                  byreg_d[i] = 1'b1;
               end else if (reg_hit && PM_WR.mode == lp_pkg::MODE_HALT) begin
                  st_d[i]    = S_HALT;
                  byreg_d[i] = 1'b1;
               end else if (INSN_NAP[i]) begin
                  st_d[i] = S_NAP;
               end else if (INSN_HALT[i]) begin
                  st_d[i] = S_HALT;
               end
            end
            S_HALT: begin
               if (wake) begin
                  st_d[i]    = S_RUN;
                  byreg_d[i] = 1'b0;
               end
            end
            S_NAP: begin
               if (wake) begin
                  st_d[i]    = S_WAKE;
                  cnt_d[i]   = 8'h00;
                  byreg_d[i] = 1'b0;
               end
            end
            S_WAKE: begin
               if (cnt_q[i] == lp_pkg::RESTORE_LAST) begin
                  st_d[i] = S_RUN;
               end else begin
                  cnt_d[i] = cnt_q[i] + 8'h01;
               end
            end
            default: begin
               st_d[i] = S_RUN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Static disables latch until reset
   always_comb begin
      cdis_d = cdis_q | CORE_DISABLE;
      bdis_d = bdis_q | BLK_DISABLE;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         for (int i = 0; i < lp_pkg::NCORES; i++) begin
            st_q[i]  <= S_RUN;
            cnt_q[i] <= 8'h00;
         end
         byreg_q <= '0;
         cdis_q  <= '0;
         bdis_q  <= '0;
      end else begin
         for (int i = 0; i < lp_pkg::NCORES; i++) begin
            st_q[i]  <= st_d[i];
            cnt_q[i] <= cnt_d[i];
         end
         byreg_q <= byreg_d;
         cdis_q  <= cdis_d;
         bdis_q  <= bdis_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core outputs decoded from state flops; block enables gate BLK_WORK directly
   always_comb begin
      for (int i = 0; i < lp_pkg::NCORES; i++) begin
         CORE_CTL[i].fetch_en = (st_q[i] == S_RUN) && !cdis_q[i];
         CORE_CTL[i].snoop_en = (st_q[i] inside {S_RUN, S_HALT})
                                && !cdis_q[i];
         CORE_CTL[i].clk_en   = (st_q[i] != S_NAP) && !cdis_q[i];
         CORE_CTL[i].retain   = (st_q[i] == S_NAP);
         CORE_BUSY[i]         = (st_q[i] != S_RUN);
      end
      // clock follows work; no latency since work gates directly
      BLK_CLK_EN = BLK_WORK & ~bdis_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // Upper bound of the nap wake window, in platform clocks
   localparam int wake_max = int'(lp_pkg::WAKE_CLKS);

   for (genvar g = 0; g < lp_pkg::NCORES; g++) begin : g_chk
      a_halt_snoop: assert property (@(posedge CLK) disable iff (RESET)
         st_q[g] == S_HALT |-> !CORE_CTL[g].fetch_en
            && (CORE_CTL[g].snoop_en || cdis_q[g]))
         else $error("halt core fetching or not snooping");
      a_nap_off: assert property (@(posedge CLK) disable iff (RESET)
         st_q[g] == S_NAP |-> !CORE_CTL[g].clk_en
            && !CORE_CTL[g].snoop_en && !CORE_CTL[g].fetch_en)
         else $error("nap core not fully gated");
      a_wake_bound: assert property (@(posedge CLK) disable iff (RESET)
         st_q[g] == S_NAP ##1 st_q[g] == S_WAKE
            |-> ##[1:wake_max] st_q[g] == S_RUN)
         else $error("nap wake too slow");
      a_halt_quick: assert property (@(posedge CLK) disable iff (RESET)
         st_q[g] == S_HALT ##1 st_q[g] == S_RUN
            |-> CORE_CTL[g].fetch_en || cdis_q[g])
         else $error("halt wake not immediate");
      a_self_nowake: assert property (@(posedge CLK) disable iff (RESET)
         byreg_q[g] && st_q[g] == S_HALT && !(PM_WR.valid
            && PM_WR.src != 2'(g)) |=> st_q[g] == S_HALT)
         else $error("register sleeper woke itself");
      a_insn_entry: assert property (@(posedge CLK) disable iff (RESET)
         st_q[g] == S_RUN && INSN_NAP[g] && !(PM_WR.valid
            && PM_WR_ALLOWED[PM_WR.src] && PM_WR.target == 2'(g))
            |=> st_q[g] == S_NAP)
         else $error("instruction nap not entered");
      a_reg_wake: assert property (@(posedge CLK) disable iff (RESET)
         st_q[g] == S_HALT && PM_WR.valid && PM_WR_ALLOWED[PM_WR.src]
            && PM_WR.target == 2'(g) && PM_WR.mode == lp_pkg::MODE_RUN
            && PM_WR.src != 2'(g) |=> st_q[g] == S_RUN)
         else $error("clear by other core did not wake");
      a_core_off: assert property (@(posedge CLK) disable iff (RESET)
         CORE_DISABLE[g] |=> !CORE_CTL[g].clk_en && !CORE_CTL[g].fetch_en)
         else $error("disabled core clock running");
      a_core_stays: assert property (@(posedge CLK) disable iff (RESET)
         cdis_q[g] |=> cdis_q[g] && !CORE_CTL[g].clk_en)
         else $error("disabled core clock came back");
      a_halt_retain: assert property (@(posedge CLK) disable iff (RESET)
         st_q[g] == S_HALT |-> !CORE_CTL[g].retain
            && (CORE_CTL[g].clk_en || cdis_q[g]))
         else $error("halt core lost its clock");
      a_wake_nofetch: assert property (@(posedge CLK) disable iff (RESET)
         st_q[g] == S_WAKE |-> !CORE_CTL[g].fetch_en && !CORE_CTL[g].retain)
         else $error("core fetching before restore done");
      a_reg_outrank: assert property (@(posedge CLK) disable iff (RESET)
         st_q[g] == S_RUN && PM_WR.valid && PM_WR_ALLOWED[PM_WR.src]
            && PM_WR.target == 2'(g) && PM_WR.mode == lp_pkg::MODE_HALT
            |=> st_q[g] == S_HALT && byreg_q[g])
         else $error("register halt not entered");
   end

   a_blk_run: assert property (@(posedge CLK) disable iff (RESET)
      (BLK_WORK & ~bdis_q) == BLK_CLK_EN)
      else $error("block clock not following work");
   // Idle blocks must not clock
   a_blk_idle: assert property (@(posedge CLK) disable iff (RESET)
      (BLK_CLK_EN & ~BLK_WORK) == '0)
      else $error("idle block clock running");
   a_blk_off: assert property (@(posedge CLK) disable iff (RESET)
      (BLK_DISABLE != '0) |=> ((BLK_CLK_EN & $past(BLK_DISABLE)) == '0))
      else $error("disabled block clock running");
   a_blk_sticky: assert property (@(posedge CLK) disable iff (RESET)
      ((BLK_CLK_EN & bdis_q) == '0)
         && ((bdis_q & $past(bdis_q)) == $past(bdis_q)))
      else $error("disabled block clock came back");

endmodule
`default_nettype wire

// ---- include/lp_pkg.sv ----
// Shared types and constants for the core low-power clock controller.
// Assumes a single 100 MHz platform clock and four cores.
package lp_pkg;
   localparam int unsigned NCORES      = 4;
   localparam int unsigned NBLOCKS     = 8;
   localparam int unsigned CLK_MHZ     = 100;
   // Wake bound from deep nap, in platform clocks
   localparam int unsigned WAKE_CLKS   = 100;
   // Clocks spent restoring supply before release
   localparam int unsigned RESTORE_CLKS = 16;
   localparam logic [7:0]  RESTORE_LAST = 8'(RESTORE_CLKS - 1);
   localparam logic [1:0]  CORE_W      = 2'h0;

   typedef enum logic [1:0] {
      MODE_RUN  = 2'h0,
      MODE_HALT = 2'h1,
      MODE_NAP  = 2'h2
   } mode_t;

   // Power register write from a core
   typedef struct packed {
      logic       valid;
      logic [1:0] src;
      logic [1:0] target;
      mode_t      mode;
   } pm_wr_t;

   // Core-facing control outputs
   typedef struct packed {
      logic fetch_en;
      logic snoop_en;
      logic clk_en;
      logic retain;
   } core_ctl_t;
endpackage

// ---- tb/core_low_power_clock_gating_bench.sv ----
// Testbench for the core low-power clock controller.
// Assumes lp_host drives the power register port.
`timescale 1ns/1ns
`default_nettype none
module core_low_power_clock_gating_bench;
   logic                  CLK = 1'b0;
   logic                  RESET = 1'b1;
   lp_pkg::pm_wr_t        pm;
   logic [3:0]            allowed = 4'hF, ihalt = '0, inap = '0;
   logic [3:0]            wake = '0, cdis = '0, busy;
   logic [7:0]            bwork = '0, bdis = '0, blk_en;
   lp_pkg::core_ctl_t [3:0] ctl;
   int                    errors = 0, total_checks = 0, cyc = 0, n;
   always #5 CLK = ~CLK;
   lp_host host (.CLK(CLK), .PM_WR(pm));
   lp_ctrl dut (.CLK(CLK), .RESET(RESET), .PM_WR(pm),
      .PM_WR_ALLOWED(allowed), .INSN_HALT(ihalt), .INSN_NAP(inap),
      .CORE_WAKE(wake), .CORE_DISABLE(cdis), .BLK_WORK(bwork),
      .BLK_DISABLE(bdis), .CORE_CTL(ctl), .CORE_BUSY(busy),
      .BLK_CLK_EN(blk_en));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic do_reset;
      @(negedge CLK) RESET = 1'b1;
      repeat (5) @(negedge CLK);
      RESET = 1'b0;
   endtask
   always @(posedge CLK) begin
      cyc++;
      // Hang guard, well past the under 100 cycles needed
      if (cyc == 5000) begin
         errors++;
         tally_and_finish;
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic halt_by_insn;
      @(negedge CLK) ihalt = 4'h4;
      @(negedge CLK) ihalt = '0;
      chk(ctl[2].fetch_en === 1'b0, "halt fetch");
      chk(ctl[2].snoop_en === 1'b1, "halt snoop");
      wake = 4'h4;
      @(negedge CLK) wake = '0;
      chk(ctl[2].fetch_en === 1'b1 && busy[2] === 1'b0, "halt wake");
   endtask
   task automatic nap_by_reg;
      host.put(2'h1, 2'h0, lp_pkg::MODE_NAP);
      chk(ctl[0] === 4'h1, "nap ctl");
      wake = 4'h1;
      @(negedge CLK) wake = '0;
      chk(busy[0] === 1'b1, "self wake");
      host.put(2'h0, 2'h0, lp_pkg::MODE_RUN);
      chk(busy[0] === 1'b1, "self clear");
      host.put(2'h1, 2'h0, lp_pkg::MODE_RUN);
      n = 0;
      while (busy[0] !== 1'b0 && n < 200) begin
         @(negedge CLK) n++;
      end
      chk(n < lp_pkg::WAKE_CLKS, "nap wake time");
      chk(ctl[0].fetch_en === 1'b1, "nap fetch back");
   endtask
   task automatic halt_by_reg;
      @(negedge CLK) allowed = 4'hD;
      host.put(2'h1, 2'h3, lp_pkg::MODE_HALT);
      chk(busy[3] === 1'b0, "unpermitted write");
      allowed = 4'hF;
      host.put(2'h0, 2'h3, lp_pkg::MODE_HALT);
      chk(ctl[3] === 4'h6 && busy[3] === 1'b1, "reg halt ctl");
      wake = 4'h8;
      @(negedge CLK) wake = '0;
      chk(busy[3] === 1'b1, "reg halt self wake");
      host.put(2'h3, 2'h3, lp_pkg::MODE_RUN);
      chk(busy[3] === 1'b1, "reg halt self clear");
      host.put(2'h0, 2'h3, lp_pkg::MODE_RUN);
      chk(ctl[3] === 4'hE && busy[3] === 1'b0, "reg wake");
   endtask
   task automatic nap_by_insn;
      @(negedge CLK) inap = 4'h2;
      @(negedge CLK) inap = '0;
      chk(ctl[1] === 4'h1 && busy[1] === 1'b1, "insn nap ctl");
      wake = 4'h2;
      @(negedge CLK) wake = '0;
      chk(ctl[1] === 4'h2, "restoring ctl");
      n = 0;
      while (busy[1] !== 1'b0 && n < 200) begin
         @(negedge CLK) n++;
      end
      chk(n == lp_pkg::RESTORE_CLKS, "insn nap restore");
      chk(ctl[1] === 4'hE, "insn nap wake");
   endtask
   task automatic block_gating;
      @(negedge CLK) bwork = 8'h08;
      #1 chk(blk_en === 8'h08, "block clock on");
      @(negedge CLK) bwork = '0;
      #1 chk(blk_en === 8'h00, "block clock off");
      bdis = 8'h08;
      cdis = 4'h2;
      @(negedge CLK) bdis = '0;
      cdis = '0;
      bwork = 8'h0C;
      @(negedge CLK) chk(blk_en === 8'h04, "block disable");
      chk(ctl[1].clk_en === 1'b0, "core disable");
      // Clocks come back only through reset
      do_reset;
      @(negedge CLK) chk(blk_en === 8'h0C, "reset restores");
      chk(ctl[1] === 4'hE, "core reset restores");
      bwork = '0;
   endtask
   initial begin
      do_reset;
      halt_by_insn;
      nap_by_reg;
      halt_by_reg;
      nap_by_insn;
      block_gating;
      tally_and_finish;
   end
endmodule
`default_nettype wire

// ---- tb/lp_host.sv ----
// Partner model: cores writing the power registers.
// Assumes CLK is shared with the controller; drives after falling edges.
`timescale 1ns/1ns
`default_nettype none
module lp_host (
   input  wire logic         CLK,
   output var lp_pkg::pm_wr_t PM_WR
);
   initial PM_WR = '0;
   task automatic put(input logic [1:0] s, input logic [1:0] t,
                      input lp_pkg::mode_t m);
      @(negedge CLK);
      PM_WR = '{valid: 1'b1, src: s, target: t, mode: m};
      // One-cycle pulse; fields only matter while valid
      @(negedge CLK);
      PM_WR = '0;
   endtask
endmodule
`default_nettype wire
